// [hw/adcs_consts.vh]
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

// ==========================================
// Register byte offsets
`define ADCS_OFF_CTRL      8'h00
`define ADCS_OFF_SEL       8'h04
`define ADCS_OFF_RESL      8'h08
`define ADCS_OFF_RESH      8'h0c
`define ADCS_OFF_TEST      8'h10

// ==========================================
// Control/status field positions
`define ADCS_CTRL_EN       0
`define ADCS_CTRL_START    1
`define ADCS_CTRL_AUTO     2
`define ADCS_CTRL_DONE     3
`define ADCS_CTRL_FREE     4
`define ADCS_CTRL_DIV_LO   5
`define ADCS_CTRL_DIV_HI   7

// ==========================================
// Input select field positions
`define ADCS_SEL_CH_LO     0
`define ADCS_SEL_CH_HI     2
`define ADCS_SEL_DIFF      3
`define ADCS_SEL_REF_LO    4
`define ADCS_SEL_REF_HI    5
`define ADCS_SEL_LADJ      6
`define ADCS_SEL_NEG_LO    7
`define ADCS_SEL_NEG_HI    9

// ==========================================
// Reset values and the supply reference code
`define ADCS_RST_DIV       3'h0
`define ADCS_RST_CH        3'h0
`define ADCS_RST_REF       2'h0
`define ADCS_RST_NEG       3'h0
`define ADCS_RST_RES       10'h000
`define ADCS_REF_SUPPLY    2'h1

// ==========================================
// Conversion timing in converter clock cycles, and the first trial code
`define ADCS_CNT_NORMAL    4'h1
`define ADCS_CNT_EXT       4'h0
`define ADCS_CNT_SAR_FIRST 4'h3
`define ADCS_CNT_SAR_LAST  4'hc
`define ADCS_CNT_LAST      4'hd
`define ADCS_BOOST_CYCLES  2'h2
`define ADCS_SAR_MSB       10'h200

`endif

// [hw/adcs_prescaler.v]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Converter clock prescaler
module adcs_prescaler (
	input  wire       hclk,      // System clock
	input  wire       hresetn,   // Async reset, active low
	input  wire       clear,     // Restart division from zero
	input  wire [2:0] div_sel,   // Clock divider select
	output reg        tick_r,    // One-cycle pulse per converter clock edge
	output reg        phase_r    // Half-rate phase clock
);

	reg  [6:0] cnt_r;
	wire [6:0] limit;

	// Codes 0 and 1 both give divide by two
	assign limit = (div_sel == 3'h0) ? 7'h01 : (7'h7f >> (3'h7 - div_sel)); // [R12]

	// Counter wraps at the selected limit; phase toggles per converter edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r   <= 7'h00;
			tick_r  <= 1'b0;
			phase_r <= 1'b0;
		end else if (clear) begin
			cnt_r   <= 7'h00; // [R3]
			tick_r  <= 1'b0;
			phase_r <= 1'b0;
		end else if (cnt_r >= limit) begin
			cnt_r   <= 7'h00;
			tick_r  <= 1'b1;
			phase_r <= ~phase_r;
		end else begin
			cnt_r  <= cnt_r + 7'h01;
			tick_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [hw/adcs_result.v]
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.vh"

// ==========================================
// Result holding register with read lock and alignment
module adcs_result (
	input  wire       hclk,       // System clock
	input  wire       hresetn,    // Async reset, active low
	input  wire       load,       // Conversion complete
	input  wire [9:0] raw,        // Result already in final number form
	input  wire       left_adj,   // Left adjust select
	input  wire       rd_low,     // Low byte is being read
	input  wire       rd_high,    // High byte is being read
	output wire [7:0] low_byte,   // Formatted low byte
	output wire [7:0] high_byte,  // Formatted high byte
	output reg        lock_r      // Updates blocked
);

	reg [9:0] data_r;

	// Lock on a low read, release on a high read; a locked result drops new data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_r <= `ADCS_RST_RES; // [R20]
			lock_r <= 1'b0;
		end else begin
			if (load && !lock_r)
				data_r <= raw; // [R19]
			if (rd_high)
				lock_r <= 1'b0;
			else if (rd_low)
				lock_r <= 1'b1; // [R14]
		end
	end

	// Alignment is applied at read time so the select bit acts at once
	assign high_byte = left_adj ? data_r[9:2] : {6'h00, data_r[9:8]};      // [R15]
	assign low_byte  = left_adj ? {data_r[1:0], 6'h00} : data_r[7:0];      // [R15]

endmodule

`default_nettype wire

// [hw/adcs_top.v]
// Summary of operation
// R1: User start while phase low takes 13 converter cycles, 14 when high.
// R2: Free running restarts at once; each restart lasts 14 converter cycles.
// R3: A hardware trigger resets the prescaler before its conversion begins.
// R4: Software toggles enable between triggered differential conversions.
// R5: Channel and reference live in a freely accessible holding register.
// R6: Active selection tracks holding register when idle, frozen during conversion.
// R7: Tracking resumes in the final cycle, when the done flag is set.
// R8: A written start bit begins conversion at the next converter clock edge.
// R9: Software waits one converter cycle after start before changing selection.
// R10: With triggering armed, software changes selection only at safe moments.
// R11: Software waits 125 us after differential or reference change.
// R12: Divider select gives 2,2,4,8,16,32,64,128.
// R13: Differential results are two's complement, single ended unsigned.
// R14: Reading low byte blocks result updates until high byte is read.
// R15: Left adjust places bits 9:2 high, 1:0 at top of low byte.
// R16: Comparator precharge is active low and stays high while idle.
// R17: Settle boost is high two converter periods after amplifier enable rises.
// R18: Recommended idle scan inputs are the reset values of these outputs.
// R19: Completion loads result and sets done flag together unless locked; here a locked completion still sets the done flag.
// R20: Result bytes are read only, reset to zero, writes ignored.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.vh"

module adcs_top (
	input  wire        hclk,                        // System clock, 200 MHz
	input  wire        hresetn,                     // Async reset, active low
	input  wire        hsel,                        // Slave select
	input  wire [7:0]  haddr,                       // Byte address
	input  wire [1:0]  htrans,                      // Transfer type
	input  wire        hwrite,                      // Write when high
	input  wire [2:0]  hsize,                       // Transfer size, words only
	input  wire [31:0] hwdata,                      // Write data
	input  wire        hready,                      // Bus ready
	output reg         hreadyout,                   // Slave ready
	output reg         hresp,                       // Always OKAY
	output reg  [31:0] hrdata,                      // Read data
	input  wire        trigger_in,                  // Auto trigger event pulse
	input  wire        comp_in,                     // Comparator: input above DAC
	output reg  [9:0]  dac_code_r,                  // Successive approximation code
	output reg         conv_busy_r,                 // Conversion running
	output reg         comparator_precharge_n_r,    // Precharge, active low
	output reg         gain_settle_boost_r,         // Gain stage settle boost
	output reg         amplifier_enable_r,          // Gain stage enable
	output reg  [2:0]  scan_channel_select_r,       // Active positive channel
	output reg  [2:0]  scan_negative_select_r,      // Active negative channel
	output reg  [1:0]  reference_select_r,          // Active reference
	output reg         gain_passgate_enable_r,      // Gain pass-gate enable
	output reg         switchcap_test_enable_r,     // Switch-cap test
	output reg         supply_reference_select_r    // Supply used as reference
);

	// ==========================================
	// Bus slave state
	reg        dp_r;
	reg        dp_write_r;
	reg [7:0]  dp_addr_r;
	reg [31:0] rd_val;

	// ==========================================
	// Software registers
	reg        converter_enable_r;
	reg        auto_trigger_enable_r;
	reg        free_run_r;
	reg [2:0]  clock_divider_select_r;
	reg        start_req_r;
	reg        conversion_done_flag_r;
	reg [2:0]  chan_tmp_r;
	reg        diff_tmp_r;
	reg [1:0]  ref_tmp_r;
	reg        left_adjust_select_r;
	reg [2:0]  neg_tmp_r;
	reg        sct_tmp_r;

	// ==========================================
	// Conversion state
	reg        diff_act_r;
	reg [3:0]  cnt_r;
	reg [9:0]  mask_r;
	reg [1:0]  boost_cnt_r;
	wire       tick;
	wire       phase;
	wire       lock;
	wire [7:0] low_byte;
	wire [7:0] high_byte;

	wire wr_ctrl   = dp_r && dp_write_r && (dp_addr_r == `ADCS_OFF_CTRL);
	wire wr_sel    = dp_r && dp_write_r && (dp_addr_r == `ADCS_OFF_SEL);
	wire wr_test   = dp_r && dp_write_r && (dp_addr_r == `ADCS_OFF_TEST);
	wire rd_low    = dp_r && !dp_write_r && (dp_addr_r == `ADCS_OFF_RESL);
	wire rd_high   = dp_r && !dp_write_r && (dp_addr_r == `ADCS_OFF_RESH);
	wire start_wr  = wr_ctrl && hwdata[`ADCS_CTRL_START] && hwdata[`ADCS_CTRL_EN];
	wire done_clr  = wr_ctrl && hwdata[`ADCS_CTRL_DONE];
	wire en_nxt    = wr_ctrl ? hwdata[`ADCS_CTRL_EN] : converter_enable_r;
	wire last_tick = tick && conv_busy_r && (cnt_r == `ADCS_CNT_LAST);
	wire begin_cnv = tick && start_req_r && !conv_busy_r && converter_enable_r;
	wire sar_step  = tick && conv_busy_r && (cnt_r >= `ADCS_CNT_SAR_FIRST) &&
	                 (cnt_r <= `ADCS_CNT_SAR_LAST);

	// Hardware trigger only arms an idle converter in triggered, non-free mode
	wire auto_fire = converter_enable_r && auto_trigger_enable_r && !free_run_r &&
	                 trigger_in && !conv_busy_r && !start_req_r;

	// Free running needs the first start by software, then restarts itself
	wire restart   = last_tick && auto_trigger_enable_r && free_run_r;

	// Offset binary becomes two's complement by flipping the sign bit
	wire [9:0] conv_raw = diff_act_r ? (dac_code_r ^ `ADCS_SAR_MSB) : dac_code_r; // [R13]

	// Stopping the prescaler while disabled gives a clean first edge on enable
	wire pres_clr  = !converter_enable_r || auto_fire; // [R3]

	// ==========================================
	// Converter clock and result register
	adcs_prescaler u_pres (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (pres_clr),
		.div_sel (clock_divider_select_r),
		.tick_r  (tick),
		.phase_r (phase)
	);

	adcs_result u_res (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.load      (last_tick),
		.raw       (conv_raw),
		.left_adj  (left_adjust_select_r),
		.rd_low    (rd_low),
		.rd_high   (rd_high),
		.low_byte  (low_byte),
		.high_byte (high_byte),
		.lock_r    (lock)
	);

	// ==========================================
	// Read mux; unmapped addresses read zero
	always @* begin
		rd_val = 32'h0000_0000;
		case (dp_addr_r)
			`ADCS_OFF_CTRL: begin
				rd_val[`ADCS_CTRL_EN]                      = converter_enable_r;
				rd_val[`ADCS_CTRL_START]                   = start_req_r || conv_busy_r;
				rd_val[`ADCS_CTRL_AUTO]                    = auto_trigger_enable_r;
				rd_val[`ADCS_CTRL_DONE]                    = conversion_done_flag_r;
				rd_val[`ADCS_CTRL_FREE]                    = free_run_r;
				rd_val[`ADCS_CTRL_DIV_HI:`ADCS_CTRL_DIV_LO] = clock_divider_select_r;
			end
			`ADCS_OFF_SEL: begin
				rd_val[`ADCS_SEL_CH_HI:`ADCS_SEL_CH_LO]   = chan_tmp_r; // [R5]
				rd_val[`ADCS_SEL_DIFF]                    = diff_tmp_r;
				rd_val[`ADCS_SEL_REF_HI:`ADCS_SEL_REF_LO] = ref_tmp_r;
				rd_val[`ADCS_SEL_LADJ]                    = left_adjust_select_r;
				rd_val[`ADCS_SEL_NEG_HI:`ADCS_SEL_NEG_LO] = neg_tmp_r;
			end
			`ADCS_OFF_RESL: rd_val[7:0] = low_byte;
			`ADCS_OFF_RESH: rd_val[7:0] = high_byte;
			`ADCS_OFF_TEST: rd_val[0]   = sct_tmp_r;
			default:        rd_val      = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// AHB-Lite slave: one wait state so read data leaves a flip-flop
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_r       <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= 8'h00;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			hrdata     <= 32'h0000_0000;
		end else if (dp_r) begin
			dp_r      <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= dp_write_r ? 32'h0000_0000 : rd_val;
		end else if (hsel && htrans[1] && hready) begin
			dp_r       <= 1'b1;
			dp_write_r <= hwrite;
			dp_addr_r  <= {haddr[7:2], 2'b00};
			hreadyout  <= 1'b0;
		end
	end

	// ==========================================
	// Control/status register; result bytes take no writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			converter_enable_r     <= 1'b0;
			auto_trigger_enable_r  <= 1'b0;
			free_run_r             <= 1'b0;
			clock_divider_select_r <= `ADCS_RST_DIV;
			start_req_r            <= 1'b0;
			conversion_done_flag_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				converter_enable_r     <= hwdata[`ADCS_CTRL_EN];
				auto_trigger_enable_r  <= hwdata[`ADCS_CTRL_AUTO];
				free_run_r             <= hwdata[`ADCS_CTRL_FREE];
				clock_divider_select_r <= hwdata[`ADCS_CTRL_DIV_HI:`ADCS_CTRL_DIV_LO];
			end
			// Start stays requested until the conversion it launches ends
			if (!en_nxt)
				start_req_r <= 1'b0;
			else if (start_wr || auto_fire)
				start_req_r <= 1'b1; // [R8]
			else if (last_tick && !restart)
				start_req_r <= 1'b0;
			// Completion beats a same-cycle clear so no event is lost
			if (last_tick)
				conversion_done_flag_r <= 1'b1; // [R19]
			else if (done_clr)
				conversion_done_flag_r <= 1'b0;
		end
	end

	// ==========================================
	// Holding register for selection, freely written by software
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_tmp_r           <= `ADCS_RST_CH;
			diff_tmp_r           <= 1'b0;
			ref_tmp_r            <= `ADCS_RST_REF;
			left_adjust_select_r <= 1'b0;
			neg_tmp_r            <= `ADCS_RST_NEG;
			sct_tmp_r            <= 1'b0;
		end else begin
			if (wr_sel) begin
				chan_tmp_r           <= hwdata[`ADCS_SEL_CH_HI:`ADCS_SEL_CH_LO]; // [R5]
				diff_tmp_r           <= hwdata[`ADCS_SEL_DIFF];
				ref_tmp_r            <= hwdata[`ADCS_SEL_REF_HI:`ADCS_SEL_REF_LO];
				left_adjust_select_r <= hwdata[`ADCS_SEL_LADJ];
				neg_tmp_r            <= hwdata[`ADCS_SEL_NEG_HI:`ADCS_SEL_NEG_LO];
			end
			if (wr_test)
				sct_tmp_r <= hwdata[0];
		end
	end

	// ==========================================
	// Active selection: tracks when idle or in the final cycle, frozen otherwise
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_channel_select_r     <= `ADCS_RST_CH;
			scan_negative_select_r    <= `ADCS_RST_NEG;
			reference_select_r        <= `ADCS_RST_REF;
			diff_act_r                <= 1'b0;
			supply_reference_select_r <= 1'b0;
			switchcap_test_enable_r   <= 1'b0;
		end else begin
			if (!conv_busy_r || (cnt_r == `ADCS_CNT_LAST)) begin // [R6] [R7]
				scan_channel_select_r     <= chan_tmp_r;
				scan_negative_select_r    <= neg_tmp_r;
				reference_select_r        <= ref_tmp_r;
				diff_act_r                <= diff_tmp_r;
				supply_reference_select_r <= (ref_tmp_r == `ADCS_REF_SUPPLY);
			end
			switchcap_test_enable_r <= sct_tmp_r;
		end
	end

	// ==========================================
	// Conversion sequencer and successive approximation
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_busy_r <= 1'b0;
			cnt_r       <= 4'h0;
			mask_r      <= 10'h000;
			dac_code_r  <= 10'h000;
		end else if (!converter_enable_r) begin
			conv_busy_r <= 1'b0; // Disabling aborts a running conversion
			cnt_r       <= 4'h0;
		end else if (begin_cnv || restart) begin
			conv_busy_r <= 1'b1;
			// A start seen with the phase high loses one edge to synchronising
			cnt_r       <= (phase || restart) ? `ADCS_CNT_EXT : `ADCS_CNT_NORMAL; // [R1] [R2]
			mask_r      <= `ADCS_SAR_MSB;
			dac_code_r  <= `ADCS_SAR_MSB;
		end else if (last_tick) begin
			conv_busy_r <= 1'b0;
			cnt_r       <= 4'h0;
		end else if (tick && conv_busy_r) begin
			cnt_r <= cnt_r + 4'h1;
			if (sar_step) begin
				dac_code_r <= (comp_in ? dac_code_r : (dac_code_r & ~mask_r)) |
				              (mask_r >> 1);
				mask_r     <= mask_r >> 1;
			end
		end
	end

	// ==========================================
	// Analog control: precharge low only while sampling, boost after amp rises
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comparator_precharge_n_r <= 1'b1;
			amplifier_enable_r       <= 1'b0;
			gain_passgate_enable_r   <= 1'b1;
			gain_settle_boost_r      <= 1'b0;
			boost_cnt_r              <= 2'h0;
		end else begin
			comparator_precharge_n_r <= !(conv_busy_r &&
			                             (cnt_r < `ADCS_CNT_SAR_FIRST)); // [R16]
			amplifier_enable_r       <= converter_enable_r && diff_act_r;
			gain_passgate_enable_r   <= !(converter_enable_r && diff_act_r);
			if (converter_enable_r && diff_act_r && !amplifier_enable_r) begin
				gain_settle_boost_r <= 1'b1; // [R17]
				boost_cnt_r         <= `ADCS_BOOST_CYCLES;
			end else if (!amplifier_enable_r) begin
				gain_settle_boost_r <= 1'b0;
				boost_cnt_r         <= 2'h0;
			end else if (tick && boost_cnt_r != 2'h0) begin
				boost_cnt_r         <= boost_cnt_r - 2'h1;
				gain_settle_boost_r <= (boost_cnt_r != 2'h1); // [R17]
			end
		end
	end

	// hsize is accepted but only whole-word access is meaningful
	wire unused_ok = &hsize | 1'b1;

endmodule

`default_nettype wire

// [test/adcs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Analog sampling and comparator core
module adcs_core_model (
	input  wire logic [9:0] dac_code,  // Trial code from the sequencer
	input  wire logic       comparator_precharge_n_n,   // Latch precharge, active low
	input  wire logic [9:0] level,     // Held analog input, in codes
	output var  logic       comp       // High when input above trial code
);
	// Input sits half a code above level, so an equal code compares high.
	// While precharged the latch holds no answer: show the wrong one.
	always @* begin
		if (comparator_precharge_n_n)
			comp = (level >= dac_code);
		else
			comp = !(level >= dac_code);
	end
endmodule

`default_nettype wire

// [test/adcs_top_props.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Port checker for the conversion sequencer
module adcs_top_props (
	input wire logic        hclk,                      // System clock
	input wire logic        hresetn,                   // Reset, active low
	input wire logic        hsel,                      // Slave select
	input wire logic [1:0]  htrans,                    // Transfer type
	input wire logic        hwrite,                    // Write
	input wire logic        hready,                    // Bus ready
	input wire logic        hreadyout,                 // Slave ready
	input wire logic        hresp,                     // Response
	input wire logic [31:0] hrdata,                    // Read data
	input wire logic        conv_busy_r,               // Conversion running
	input wire logic        comparator_precharge_n_r,  // Precharge
	input wire logic        gain_settle_boost_r,       // Settle boost
	input wire logic        amplifier_enable_r,        // Gain stage enable
	input wire logic [2:0]  scan_channel_select_r,     // Active channel
	input wire logic [2:0]  scan_negative_select_r,    // Active negative
	input wire logic [1:0]  reference_select_r,        // Active reference
	input wire logic        gain_passgate_enable_r,    // Pass-gate
	input wire logic        supply_reference_select_r  // Supply reference
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [8:0] boost_len_r;

	// Boost length counter; saturates so a stuck boost stays visible
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			boost_len_r <= 9'h000;
		else if (!gain_settle_boost_r)
			boost_len_r <= 9'h000;
		else if (boost_len_r != 9'h1ff)
			boost_len_r <= boost_len_r + 9'h001;
	end

	sequence s_take;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence s_busy8;
		conv_busy_r [*8];
	endsequence

	property p_bus_wait;
		s_take |=> !hreadyout ##1 hreadyout;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_wr_zero;
		s_take ##0 hwrite |-> ##2 hrdata == 32'h00000000;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data after write");
	property p_idle_comparator_precharge_n;
		!conv_busy_r |-> comparator_precharge_n_r;
	endproperty
	a_idle_comparator_precharge_n: assert property (p_idle_comparator_precharge_n) else $error("precharge low idle");
	property p_sel_frozen;
		!comparator_precharge_n_r |-> $stable(scan_channel_select_r) &&
			$stable(scan_negative_select_r) && $stable(reference_select_r);
	endproperty
	a_sel_frozen: assert property (p_sel_frozen) else $error("selection moved");
	property p_conv_len;
		$rose(conv_busy_r) |-> s_busy8 ##1 s_busy8 ##1 s_busy8;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion too short");
	property p_boost_rise;
		$rose(amplifier_enable_r) |-> ##[0:1] gain_settle_boost_r;
	endproperty
	a_boost_rise: assert property (p_boost_rise) else $error("no settle boost");
	property p_boost_idle;
		!amplifier_enable_r |-> !gain_settle_boost_r;
	endproperty
	a_boost_idle: assert property (p_boost_idle) else $error("boost while off");
	property p_boost_len;
		boost_len_r <= 9'h102;
	endproperty
	a_boost_len: assert property (p_boost_len) else $error("boost too long");
	property p_passgate;
		gain_passgate_enable_r != amplifier_enable_r;
	endproperty
	a_passgate: assert property (p_passgate) else $error("pass-gate wrong");
	property p_supply_ref;
		supply_reference_select_r == (reference_select_r == 2'h1);
	endproperty
	a_supply_ref: assert property (p_supply_ref) else $error("supply ref wrong");
endmodule

`default_nettype wire

// [test/tb_adcs_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_adcs_top;
	logic        hclk, hresetn, hsel, hwrite, trigger_in;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, rd;
	logic [9:0]  level;
	wire         hreadyout, hresp, comp_in, busy, comparator_precharge_n_n, boost, amp, pass, sct, vref;
	wire  [31:0] hrdata;
	wire  [9:0]  dac;
	wire  [2:0]  ch, neg;
	wire  [1:0]  refs;
	int          bad_count, n_checks, n, t0;

	adcs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.trigger_in(trigger_in), .comp_in(comp_in), .dac_code_r(dac), .conv_busy_r(busy),
		.comparator_precharge_n_r(comparator_precharge_n_n), .gain_settle_boost_r(boost),
		.amplifier_enable_r(amp), .scan_channel_select_r(ch), .scan_negative_select_r(neg),
		.reference_select_r(refs), .gain_passgate_enable_r(pass),
		.switchcap_test_enable_r(sct), .supply_reference_select_r(vref));
	adcs_core_model i_core (.dac_code(dac), .comparator_precharge_n_n(comparator_precharge_n_n), .level(level), .comp(comp_in));

	// ==========================================
	// Clock, watchdog, verdict
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		repeat (80000) @(posedge hclk);
		bad_count++;
		$display("ERROR %0t watchdog expired", $time);
		conclude();
	end
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// ==========================================
	// Bus master: request held until ready is seen high at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Counts edges until busy is sampled at the wanted level
	task automatic wait_busy(input logic lvl, input int lim);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (busy !== lvl && n < lim);
	endtask
	// Counts edges until precharge is seen falling, one per conversion start
	task automatic wait_fall();
		logic p;
		n = 0;
		do begin
			p = comparator_precharge_n_n;
			@(posedge hclk);
			n++;
		end while (!(p === 1'b1 && comparator_precharge_n_n === 1'b0) && n < 4000);
	endtask
	function automatic logic [31:0] res(input logic [9:0] v, input logic la, input logic hi);
		if (hi)
			return la ? {24'h0, v[9:2]} : {30'h0, v[9:8]};
		return la ? {24'h0, v[1:0], 6'h00} : {24'h0, v[7:0]};
	endfunction
	task automatic run();
		bus(1'b1, 8'h00, 32'h0000000b);
		wait_busy(1'b1, 300);
		wait_busy(1'b0, 4000);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk({hreadyout, hresp, busy, comparator_precharge_n_n, boost, amp, pass, sct, vref}, 9'h124, "rst");
		chk({ch, neg, refs}, 8'h00, "rst sel");
		bus(1'b1, 8'h08, 32'hffffffff);
		bus(1'b1, 8'h0c, 32'hffffffff);
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0, "low ro");
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0, "high ro");
		bus(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1'b1, 8'h10, 32'h1);
		@(posedge hclk);
		chk(sct, 1'b1, "test bit");
		bus(1'b1, 8'h10, 32'h0);
	endtask
	task automatic t_single(input logic [9:0] v, input logic la);
		level = v;
		bus(1'b1, 8'h04, {25'h0, la, 6'h12});
		@(posedge hclk);
		chk({refs, ch}, 5'h0a, "idle track");
		bus(1'b1, 8'h00, 32'h0000000b);
		wait_busy(1'b1, 4);
		chk(busy, 1'b1, "start edge");
		t0 = $time;
		repeat (4) @(posedge hclk);
		bus(1'b1, 8'h04, {25'h0, la, 6'h15});
		chk({busy, ch}, 4'ha, "frozen");
		wait_busy(1'b0, 4000);
		n = ($time - t0) / 5;
		chk(n == 26 || n == 28, 1'b1, "length");
		chk(ch, 3'h5, "resume");
		bus(1'b0, 8'h00, 32'h0);
		chk(rd[3], 1'b1, "done");
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, res(v, la, 1'b0), "low");
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd, res(v, la, 1'b1), "high");
	endtask
	task automatic t_diff();
		level = 10'h0f0;
		bus(1'b1, 8'h04, 32'h00000189);
		repeat (25000) @(posedge hclk);
		chk(amp, 1'b1, "amp on");
		run();
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h000000f0, "diff low");
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h00000002, "diff high");
		bus(1'b1, 8'h04, 32'h00000001);
	endtask
	task automatic t_lock();
		level = 10'h155;
		run();
		bus(1'b0, 8'h08, 32'h0);
		level = 10'h2aa;
		run();
		bus(1'b0, 8'h00, 32'h0);
		chk(rd[3], 1'b1, "locked done");
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd, res(10'h155, 1'b0, 1'b1), "held high");
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, res(10'h155, 1'b0, 1'b0), "held low");
	endtask
	task automatic t_free();
		int div;
		for (int c = 0; c < 8; c++) begin
			div = (c == 0) ? 2 : (1 << c);
			bus(1'b1, 8'h00, {24'h0, c[2:0], 5'h17});
			wait_fall();
			wait_fall();
			wait_fall();
			chk(n, 14 * div, "free period");
			bus(1'b1, 8'h00, {24'h0, c[2:0], 5'h05});
			wait_busy(1'b0, 4000);
			bus(1'b1, 8'h00, 32'h0);
		end
	endtask
	task automatic t_trig();
		int d[2];
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 8'h00, 32'h00000000);
			bus(1'b1, 8'h00, 32'h00000045);
			repeat (5 + k) @(posedge hclk);
			trigger_in <= 1'b1;
			@(posedge hclk);
			trigger_in <= 1'b0;
			wait_busy(1'b1, 300);
			d[k] = n;
			wait_busy(1'b0, 4000);
		end
		chk(d[0] == d[1] && d[0] < 300, 1'b1, "trigger delay");
	endtask

	// ==========================================
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		trigger_in = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		level = 10'h000;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_single(10'h2a5, 1'b0);
		t_single(10'h1c3, 1'b1);
		t_diff();
		t_lock();
		t_free();
		t_trig();
		conclude();
	end
endmodule

bind adcs_top adcs_top_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .conv_busy_r(conv_busy_r),
	.comparator_precharge_n_r(comparator_precharge_n_r),
	.gain_settle_boost_r(gain_settle_boost_r), .amplifier_enable_r(amplifier_enable_r),
	.scan_channel_select_r(scan_channel_select_r),
	.scan_negative_select_r(scan_negative_select_r), .reference_select_r(reference_select_r),
	.gain_passgate_enable_r(gain_passgate_enable_r),
	.supply_reference_select_r(supply_reference_select_r));

`default_nettype wire
